// ---- hdl/io_link_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the expansion link manager.
// Assumes a 20 MHz bus clock and a word-aligned AHB-Lite register map.
`ifndef IO_LINK_CFG_SVH
`define IO_LINK_CFG_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_OUT 8'h04
`define OFF_STATUS 8'h08
`define OFF_CFG_ID 8'h0C
`define OFF_STAMP 8'h10
`define OFF_HW_ID 8'h14
`define OFF_FW 8'h18
`define OFF_NAME 8'h20
`define NAME_WORDS 4
// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define CTRL_BITS 6
`define CTRL_RESET 6'h00
`define ST_LOWER 12
`define ST_UPPER 13
`define ST_HEALTH 16
`define ST_MARKER 17
`define NAME_BLANK 32'h20202020
`define RELAY_MASK 8'hC0
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_HZ 20000000
`define LOCAL_OUT_MS 15
`define REMOTE_OUT_MS 40
`define LOCAL_PERIOD_CYC (`LOCAL_OUT_MS * (`CLK_HZ / 1000))
`define REMOTE_PERIOD_CYC (`REMOTE_OUT_MS * (`CLK_HZ / 1000))
`define FRAME_BITS 16
`define BIT_DIV 8
`endif

// ---- hdl/io_link_pkg.sv ----
// Types shared by the expansion link manager and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package io_link_pkg;
  // Control register fields, most significant first, so used is bit 0.
  typedef struct packed {
    logic run;
    logic local_chg;
    logic skip;
    logic relay_var;
    logic remote;
    logic used;
  } ctrl_t;
  // Word returned by the expansion, first bit received is ack.
  typedef struct packed {
    logic ack;
    logic spare;
    logic upper_fault;
    logic lower_fault;
    logic [11:0] inputs;
  } rx_frame_t;
  // Bus request held from address phase into data phase.
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } ahb_req_t;
  typedef enum logic [1:0] {LK_IDLE = 2'b01, LK_SHIFT = 2'b10} link_state_t;
endpackage

// ---- hdl/io_expansion_link_manager.sv ----
// Expansion link manager: AHB-Lite registers plus the serial exchange with one expansion.
// Assumes a single 20 MHz clock, inputs synchronous to it, and a zero-wait bus master.
// Summary of operation
// (RL1) Referenced expansion contacts mark expansion attached.
// (RL2) Images exchanged serially in both directions.
// (RL3) Expansion inputs bypass the debounce filter.
// (RL4) Local: inputs 30 ms, outputs 15 ms.
// (RL5) Remote: inputs 80 ms, outputs 40 ms.
// (RL6) Twelve input and eight output identifiers.
// (RL7) Relay variant: outputs seven, eight internal only.
// (RL8) Link down: inputs and fault flags read 0.
// (RL9) Link down: output writes not applied.
// (RL10) Health flag 0 working, 1 failed.
// (RL11) Lower flag: fault on outputs one-four.
// (RL12) Upper flag: fault on outputs five-eight.
// (RL13) Skipped scan holds previous output states.
// (RL14) Program name sixteen characters, blank default.
// (RL15) Record time of last configuration change.
// (RL16) Checksum and version as four hex digits.
// (RL17) Local configuration reports version all zeros.
// (RL18) Detection code: supply, output type, network.
// (RL19) Firmware checksum shown only when stopped.
// (RL20) Revision from first two serial digits.
// (RL21) Missed reply sets health, success clears.
// (RL22) Exchange carries full images and faults.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "io_link_cfg.svh"
module io_expansion_link_manager import io_link_pkg::*; #(
  parameter int LOCAL_PERIOD = `LOCAL_PERIOD_CYC,
  parameter int REMOTE_PERIOD = `REMOTE_PERIOD_CYC,
  parameter int BIT_DIV = `BIT_DIV,
  parameter logic [15:0] FW_VERSION = 16'h0100, // Arbitrary value.
  parameter logic [15:0] FW_CHECKSUM = 16'h1234 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial link to the expansion.
  output logic link_clk,
  output logic link_frame,
  output logic link_tx,
  input wire logic link_rx,
  // Hardware straps.
  input wire logic strap_ac,
  input wire logic strap_relay,
  input wire logic strap_net,
  input wire logic [7:0] strap_serial_rev,
  // Flags for the program.
  output logic expansion_health_flag,
  output logic lower_output_fault_flag,
  output logic upper_output_fault_flag,
  output logic first_scan_done_marker
);
  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  // The bit divider counter is 16 bits wide and the period counter 20 bits wide.
  generate
    if (BIT_DIV < 2 || BIT_DIV > 65535 || 2 * `FRAME_BITS * BIT_DIV >= LOCAL_PERIOD ||
        2 * `FRAME_BITS * BIT_DIV >= REMOTE_PERIOD ||
        LOCAL_PERIOD >= (1 << 20) || REMOTE_PERIOD >= (1 << 20)) begin : g_bad
      $error("io_expansion_link_manager: unusable timing parameters");
    end
  endgenerate

  // Tests whether a held or live address selects a word at the given offset.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  ctrl_t ctrl_ff;
  ahb_req_t req_ff, nxt_req;
  link_state_t state_ff;
  logic [31:0] hrdata_ff, cfg_id_ff, stamp_ff;
  logic [31:0] name_ff [`NAME_WORDS];
  logic [7:0] out_stage_ff, out_img_ff;
  logic [11:0] in_img_ff;
  logic lower_ff, upper_ff, health_ff, marker_ff, hready_ff;
  logic [19:0] per_cnt_ff;
  logic [15:0] div_ff;
  logic phase_ff, clk_ff, frame_ff, tx_ff;
  logic [4:0] bit_cnt_ff;
  logic [15:0] tx_sh_ff, rx_sh_ff;
  logic [15:0] hw_id_ff;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Address phase capture and write strobes for the data phase.
  wire addr_ok = hsel & htrans[1] & hready;
  wire wr_en = req_ff.valid & req_ff.write;
  wire wr_ctrl = wr_en & hit(req_ff.addr, `OFF_CTRL);
  wire wr_out = wr_en & hit(req_ff.addr, `OFF_OUT);
  wire wr_cfg = wr_en & hit(req_ff.addr, `OFF_CFG_ID);
  wire wr_stamp = wr_en & hit(req_ff.addr, `OFF_STAMP);
  wire wr_name = wr_en & (req_ff.addr[7:4] == 4'(`OFF_NAME >> 4));
  wire [1:0] name_idx = req_ff.addr[3:2];
  assign nxt_req = '{addr: haddr[7:0], write: hwrite, valid: addr_ok};

  // Read fields; the version reads zero for a locally made configuration.
  wire [15:0] rd_ver = ctrl_ff.local_chg ? 16'h0000 : cfg_id_ff[31:16]; // RL17
  wire [15:0] rd_fw_crc = ctrl_ff.run ? 16'h0000 : FW_CHECKSUM; // RL19
  wire [31:0] rd_status = {14'h0000, marker_ff, health_ff, 2'h0, upper_ff, lower_ff,
                           in_img_ff};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_word =
    hit(ra, `OFF_CTRL) ? {26'h0000000, ctrl_ff} :
    hit(ra, `OFF_OUT) ? {24'h000000, out_stage_ff} :
    hit(ra, `OFF_STATUS) ? rd_status :
    hit(ra, `OFF_CFG_ID) ? {rd_ver, cfg_id_ff[15:0]} : // RL16
    hit(ra, `OFF_STAMP) ? stamp_ff : // RL15
    hit(ra, `OFF_HW_ID) ? {16'h0000, hw_id_ff} :
    hit(ra, `OFF_FW) ? {rd_fw_crc, FW_VERSION} :
    (ra[7:4] == 4'(`OFF_NAME >> 4)) ? name_ff[ra[3:2]] : 32'h00000000;

  // Bus pipeline: zero wait states, read data loaded at the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
      hrdata_ff <= 32'h00000000;
      hready_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      hready_ff <= 1'b1;
      if (addr_ok && !hwrite) begin
        hrdata_ff <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  // Control, staged outputs, configuration identity and change stamp.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `CTRL_RESET;
      out_stage_ff <= 8'h00;
      cfg_id_ff <= 32'h00000000;
      stamp_ff <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[`CTRL_BITS-1:0]; // RL1
      end
      if (wr_out) begin
        out_stage_ff <= hwdata[7:0]; // RL6
      end
      if (wr_cfg) begin
        cfg_id_ff <= hwdata; // RL16
      end
      if (wr_stamp) begin
        stamp_ff <= hwdata; // RL15
      end
    end
  end

  // Program name, blank after reset until software fills it in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `NAME_WORDS; i++) begin
        name_ff[i] <= `NAME_BLANK; // RL14
      end
    end else if (wr_name) begin
      name_ff[name_idx] <= hwdata;
    end
  end

  // Detection code and revision, taken from the straps every cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_id_ff <= 16'h0000;
    end else begin
      hw_id_ff <= {strap_serial_rev, 5'h00, strap_net, strap_relay, strap_ac}; // RL18 RL20
    end
  end

  // ---------------------------------------------------------------------------
  // Link sequencing
  // ---------------------------------------------------------------------------
  // Exchange period follows the coupling so the output deadline is met.
  wire [19:0] period = ctrl_ff.remote ? REMOTE_PERIOD[19:0] : LOCAL_PERIOD[19:0]; // RL4 RL5
  wire start = (state_ff == LK_IDLE) && (per_cnt_ff == 20'h00000) && ctrl_ff.used; // RL1
  wire tick = (state_ff == LK_SHIFT) && (div_ff == BIT_DIV[15:0] - 16'h0001);
  wire last = tick && phase_ff && (bit_cnt_ff == 5'(`FRAME_BITS - 1));
  // A skipped scan keeps the last committed outputs.
  wire [7:0] nxt_out_img = ctrl_ff.skip ? out_img_ff : out_stage_ff; // RL13
  // Relay variant never drives the two upper outputs onto terminals.
  wire [7:0] phys_out = nxt_out_img & (ctrl_ff.relay_var ? ~`RELAY_MASK : 8'hFF); // RL7
  // Outputs are applied by the expansion only while the link is healthy.
  wire [15:0] tx_word = {~health_ff, 7'h00, phys_out}; // RL9 RL22
  rx_frame_t rx_f;
  assign rx_f = rx_sh_ff;

  // Period counter and frame state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_ff <= 20'h00000;
      state_ff <= LK_IDLE;
      out_img_ff <= 8'h00;
    end else begin
      if (start) begin
        per_cnt_ff <= period - 20'h00001;
        state_ff <= LK_SHIFT;
        out_img_ff <= nxt_out_img; // RL13
      end else begin
        if (per_cnt_ff != 20'h00000) begin
          per_cnt_ff <= per_cnt_ff - 20'h00001;
        end
        if (last) begin
          state_ff <= LK_IDLE;
        end
      end
    end
  end

  // Bit timing: clock low while data settles, high while the reply is sampled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 16'h0000;
      phase_ff <= 1'b0;
      bit_cnt_ff <= 5'h00;
      clk_ff <= 1'b0;
      frame_ff <= 1'b0;
      tx_ff <= 1'b0;
      tx_sh_ff <= 16'h0000;
      rx_sh_ff <= 16'h0000;
    end else if (start) begin
      div_ff <= 16'h0000;
      phase_ff <= 1'b0;
      bit_cnt_ff <= 5'h00;
      frame_ff <= 1'b1;
      tx_sh_ff <= tx_word; // RL2
      tx_ff <= tx_word[15];
    end else if (state_ff == LK_SHIFT) begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
      if (tick) begin
        phase_ff <= ~phase_ff;
        clk_ff <= ~phase_ff;
        if (!phase_ff) begin
          rx_sh_ff <= {rx_sh_ff[14:0], link_rx}; // RL2
        end else if (last) begin
          frame_ff <= 1'b0;
          tx_ff <= 1'b0;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 5'h01;
          tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
          tx_ff <= tx_sh_ff[14];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reply evaluation
  // ---------------------------------------------------------------------------
  // A good reply loads inputs and faults raw; a bad one or no use clears them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      health_ff <= 1'b1;
      in_img_ff <= 12'h000;
      lower_ff <= 1'b0;
      upper_ff <= 1'b0;
    end else if (!ctrl_ff.used || (last && !rx_f.ack)) begin
      health_ff <= 1'b1; // RL10 RL21
      in_img_ff <= 12'h000; // RL8
      lower_ff <= 1'b0; // RL8
      upper_ff <= 1'b0;
    end else if (last) begin
      health_ff <= 1'b0; // RL21
      in_img_ff <= rx_f.inputs; // RL3 RL6 RL22
      lower_ff <= rx_f.lower_fault; // RL11
      upper_ff <= rx_f.upper_fault; // RL12
    end
  end

  // Marker set once a scan has run with the expansion working.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      marker_ff <= 1'b0;
    end else if (start && !ctrl_ff.skip && !health_ff) begin
      marker_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign link_clk = clk_ff;
  assign link_frame = frame_ff;
  assign link_tx = tx_ff;
  assign expansion_health_flag = health_ff; // RL10
  assign lower_output_fault_flag = lower_ff;
  assign upper_output_fault_flag = upper_ff;
  assign first_scan_done_marker = marker_ff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Reply handling and the flags while the link is down.
  a_health_bad_reply: assert property (last && !rx_f.ack |=> health_ff) // RL21
    else $error("Bad reply did not raise health flag.");
  a_health_good_reply: assert property (last && rx_f.ack && ctrl_ff.used |=> !health_ff) // RL21
    else $error("Good reply did not clear health flag.");
  a_inputs_zero_down: assert property (health_ff |-> in_img_ff == 12'h000) // RL8
    else $error("Inputs nonzero while link down.");
  a_faults_zero_down: assert property (health_ff |-> !lower_ff && !upper_ff) // RL8
    else $error("Fault flags nonzero while link down.");
  a_health_unused: assert property (!ctrl_ff.used |=> health_ff) // RL10
    else $error("Health flag clear with no expansion in use.");
  a_unused_quiet: assert property (!ctrl_ff.used && state_ff == LK_IDLE |=> !frame_ff) // RL1
    else $error("Frame started with no expansion in use.");

  // Frame shape, the committed output image, reply sampling and fault flag loads.
  a_clk_idle_low: assert property (!frame_ff |-> !clk_ff && !tx_ff) // RL2
    else $error("Link clock or data active outside a frame.");
  a_no_apply_down: assert property ($rose(frame_ff) |-> tx_ff == !$past(health_ff)) // RL9
    else $error("Apply bit does not follow link health.");
  a_relay_upper_off: assert property ($rose(frame_ff) && ctrl_ff.relay_var
                                      |-> tx_sh_ff[7:6] == 2'b00) // RL7
    else $error("Relay variant drove outputs seven or eight.");
  a_skip_holds_out: assert property (start && ctrl_ff.skip |=> $stable(out_img_ff)) // RL13
    else $error("Skipped scan changed outputs.");
  a_out_commit: assert property (start && !ctrl_ff.skip // RL13
                                 |=> out_img_ff == $past(out_stage_ff))
    else $error("Staged outputs not committed at frame start.");
  a_rx_sample: assert property (tick && !phase_ff // RL2
                                |=> rx_sh_ff[0] == $past(link_rx))
    else $error("Reply bit not sampled at link clock rise.");
  a_lower_fault_load: assert property (last && rx_f.ack && ctrl_ff.used
                                       |=> lower_ff == $past(rx_f.lower_fault)) // RL11
    else $error("Lower fault flag not loaded.");
  a_upper_fault_load: assert property (last && rx_f.ack && ctrl_ff.used
                                       |=> upper_ff == $past(rx_f.upper_fault)) // RL12
    else $error("Upper fault flag not loaded.");

  // Register read views as they reach the read data flops, and the frame start.
  a_local_version: assert property (addr_ok && !hwrite && hit(ra, `OFF_CFG_ID) && // RL17
                                    ctrl_ff.local_chg |=> hrdata_ff[31:16] == 16'h0000)
    else $error("Local configuration shows nonzero version.");
  a_fw_crc_run: assert property (addr_ok && !hwrite && hit(ra, `OFF_FW) && // RL19
                                 ctrl_ff.run |=> hrdata_ff[31:16] == 16'h0000)
    else $error("Firmware checksum visible while running.");
  a_frame_starts: assert property (start |=> frame_ff && state_ff == LK_SHIFT) // RL2
    else $error("Exchange did not start.");

  // Main scenarios: good and bad replies, skipped scan, recovery, relay variant.
  c_good_exchange: cover property (last && rx_f.ack && ctrl_ff.used);
  c_bad_exchange: cover property (last && !rx_f.ack);
  c_skipped_scan: cover property (start && ctrl_ff.skip);
  c_link_recovers: cover property ($fell(health_ff));
  c_relay_frame: cover property (start && ctrl_ff.relay_var);
endmodule
`default_nettype wire

// ---- verif/expansion_model.sv ----
// Behavioural expansion module that faces the link manager across the serial link.
// Assumes the bench sets the reply and the alive flag only while no frame runs.
`timescale 1ns/1ps
`default_nettype none
module expansion_model import io_link_pkg::*; (
  // Serial link from the basic unit.
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_tx,
  output logic link_rx,
  // Bench control of the reply.
  input wire logic alive,
  input wire rx_frame_t reply,
  // Observed traffic.
  output logic [15:0] got,
  output logic [7:0] applied,
  output logic done
);
  logic [15:0] sh_in;
  logic [15:0] sh_out;
  int n;
  // -----------------------------------------------------------------------------
  // Frame handling
  // -----------------------------------------------------------------------------
  // Start quiet so the line is never unknown.
  initial begin
    link_rx = 1'h0;
    got = '0;
    applied = '0;
    done = 1'h0;
    sh_in = '0;
    sh_out = '0;
    n = 16;
  end
  // Load the reply at frame start; a dead module never acknowledges.
  always @(posedge link_frame) begin
    n = 0;
    sh_out = alive ? {1'h1, reply[14:0]} : {1'h0, 15'h5555};
    link_rx = sh_out[15];
  end
  // Take each output bit while the link clock is high.
  always @(posedge link_clk) begin
    sh_in = {sh_in[14:0], link_tx};
    n = n + 1;
  end
  // Move to the next reply bit at the start of each bit; the count stops a stray shift.
  always @(negedge link_clk) begin
    if (n < 16) begin
      sh_out = {sh_out[14:0], 1'h0};
      link_rx = sh_out[15];
    end
  end
  // Publish the frame; outputs are taken only when the apply bit is set.
  always @(negedge link_frame) begin
    got = sh_in;
    if (n == 16 && sh_in[15]) begin
      applied = sh_in[7:0];
    end
    link_rx = ~link_rx;
    done = ~done;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench: AHB-Lite master, expansion model and queued result checks.
// Assumes io_link_pkg, io_link_cfg.svh and expansion_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "io_link_cfg.svh"
module tb import io_link_pkg::*;;
  localparam logic [15:0] FWV = 16'h0A51; // Arbitrary value.
  localparam logic [15:0] FWC = 16'h5C3E; // Arbitrary value.
  localparam logic [31:0] USED = 32'h1, REM = 32'h2, RLY = 32'h4, SKP = 32'h8, LCH = 32'h10;
  logic hclk = 1'h0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph, alive, mdone;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [31:0] seed = 32'h937186E1;
  logic [1:0] htrans;
  logic link_clk, link_frame, link_tx, link_rx, s_ac, s_rel, s_net;
  logic expansion_health_flag, lower_output_fault_flag, upper_output_fault_flag;
  logic first_scan_done_marker;
  logic [7:0] s_rev, o, o2, applied;
  logic [15:0] got;
  rx_frame_t reply;
  logic [31:0] rq[$];
  string nq[$];
  logic [15:0] fq[$];
  int bad_count = 0;
  int total_checks = 0;
  int k;
  // -----------------------------------------------------------------------------
  // Clock, design and partner
  // -----------------------------------------------------------------------------
  // The single slave's ready is the bus ready.
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  io_expansion_link_manager #(.LOCAL_PERIOD(600), .REMOTE_PERIOD(1000), .BIT_DIV(8),
    .FW_VERSION(FWV), .FW_CHECKSUM(FWC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_clk(link_clk), .link_frame(link_frame), .link_tx(link_tx), .link_rx(link_rx),
    .strap_ac(s_ac), .strap_relay(s_rel), .strap_net(s_net), .strap_serial_rev(s_rev),
    .expansion_health_flag(expansion_health_flag),
    .lower_output_fault_flag(lower_output_fault_flag),
    .upper_output_fault_flag(upper_output_fault_flag),
    .first_scan_done_marker(first_scan_done_marker));
  expansion_model partner (.link_clk(link_clk), .link_frame(link_frame), .link_tx(link_tx),
    .link_rx(link_rx), .alive(alive), .reply(reply), .got(got), .applied(applied),
    .done(mdone));
  // -----------------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkf(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED frame expected %h seen %h", e, g);
    end
  endtask
  // Waits for the next edge at which the bus ready is sampled high.
  task automatic wait_rdy();
    int j;
    j = 0;
    do begin
      @(posedge hclk);
      j++;
    end while (hready !== 1'h1 && j < 50);
    if (hready !== 1'h1) begin
      bad_count++;
      conclude();
    end
  endtask
  // One single transfer; a read notes its expected word for the monitor.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input string n);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    if (!w) begin
      rq.push_back(e);
      nq.push_back(n);
    end
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    wait_rdy();
    rd_ph <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 32'h0, "");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'h0, a, 32'h0, e, n);
  endtask
  task automatic wait_lvl(input logic v);
    int j;
    j = 0;
    while (link_frame !== v && j < 3000) begin
      @(posedge hclk);
      j++;
    end
    if (link_frame !== v) begin
      bad_count++;
      conclude();
    end
  endtask
  // Notes the image expected in the next frame and lets the flags settle after it.
  task automatic frame(input logic [15:0] e);
    wait_lvl(1'h1);
    fq.push_back(e);
    wait_lvl(1'h0);
    repeat (2) @(posedge hclk);
  endtask
  // Counts the clock cycles from one frame start to the next.
  task automatic period(input logic [31:0] e);
    int j;
    j = 0;
    wait_lvl(1'h0);
    wait_lvl(1'h1);
    do begin
      @(posedge hclk);
      j++;
    end while (link_frame === 1'h1 && j < 5000);
    do begin
      @(posedge hclk);
      j++;
    end while (link_frame !== 1'h1 && j < 5000);
    chk("frame period", e, j);
  endtask
  // -----------------------------------------------------------------------------
  // Result monitors
  // -----------------------------------------------------------------------------
  // Read data is taken at the edge that ends the data phase.
  always @(posedge hclk) begin
    if (rd_ph === 1'h1 && hready === 1'h1) begin
      chk(nq.pop_front(), rq.pop_front(), hrdata);
    end
  end
  // Each finished frame is compared with the oldest noted image.
  always @(mdone) begin
    if (fq.size() > 0) begin
      chkf(fq.pop_front(), got);
    end
  end
  // -----------------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------------
  initial begin
    r = xs();
    s_ac <= r[0];
    s_rel <= r[1];
    s_net <= r[2];
    s_rev <= r[15:8];
    hresetn <= 1'h0;
    hsel <= 1'h0;
    htrans <= 2'h0;
    haddr <= 32'h0;
    hwrite <= 1'h0;
    hwdata <= 32'h0;
    rd_ph <= 1'h0;
    alive <= 1'h1;
    reply <= 16'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    rd(`OFF_CTRL, 32'h0, "ctrl reset");
    rd(`OFF_STATUS, 32'h0001_0000, "status reset");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "unmapped");
    wr(`OFF_HW_ID, 32'hFFFF_FFFF);
    rd(`OFF_HW_ID, {16'h0, s_rev, 5'h0, s_net, s_rel, s_ac}, "hw id");
    rd(`OFF_FW, {FWC, FWV}, "fw stopped");
    wr(`OFF_CTRL, 32'h20);
    rd(`OFF_FW, {16'h0, FWV}, "fw running");
    r = xs();
    wr(`OFF_CFG_ID, r);
    rd(`OFF_CFG_ID, r, "cfg id");
    wr(`OFF_CTRL, LCH);
    rd(`OFF_CFG_ID, {16'h0, r[15:0]}, "cfg local");
    r = xs();
    wr(`OFF_STAMP, r);
    rd(`OFF_STAMP, r, "stamp");
    for (int i = 0; i < `NAME_WORDS; i++) begin
      rd(`OFF_NAME + 8'(4 * i), `NAME_BLANK, "name blank");
      r = xs();
      wr(`OFF_NAME + 8'(4 * i), r);
      rd(`OFF_NAME + 8'(4 * i), r, "name");
    end
    wr(`OFF_CTRL, 32'h0);
    k = 0;
    repeat (700) begin
      @(posedge hclk);
      if (link_frame !== 1'h0) k++;
    end
    chk("frames while unused", 32'h0, k);
    chk("bus response", 32'h0, {31'h0, hresp});
    $display("test registers done");
    r = xs();
    o = r[7:0] & 8'h3F;
    reply <= {1'h1, r[30:16]};
    wr(`OFF_OUT, {24'h0, o});
    wr(`OFF_CTRL, USED);
    frame({8'h00, o});
    frame({8'h80, o});
    for (int i = 0; i < 4; i++) begin
      r = xs();
      reply <= {1'h1, 1'h0, i[1], i[0], r[11:0]};
      frame({8'h80, o});
      rd(`OFF_STATUS, {14'h0, 2'h2, 2'h0, i[1], i[0], r[11:0]}, "status");
      chk("fault flags", {30'h0, i[1], i[0]},
          {30'h0, upper_output_fault_flag, lower_output_fault_flag});
    end
    chk("marker", 32'h1, {31'h0, first_scan_done_marker});
    $display("test exchange done");
    r = xs();
    o2 = r[7:0] | 8'hC0;
    wr(`OFF_CTRL, USED | SKP);
    wr(`OFF_OUT, {24'h0, o2});
    frame({8'h80, o});
    wr(`OFF_CTRL, USED | RLY);
    frame({8'h80, 2'h0, o2[5:0]});
    $display("test skip and relay done");
    alive <= 1'h0;
    wr(`OFF_CTRL, USED);
    frame({8'h80, o2});
    rd(`OFF_STATUS, 32'h0003_0000, "status down");
    wr(`OFF_OUT, {24'h0, o});
    alive <= 1'h1;
    frame({8'h00, o});
    chk("applied image", {24'h0, o2}, {24'h0, applied});
    chk("health", 32'h0, {31'h0, expansion_health_flag});
    $display("test link loss done");
    period(32'd600);
    wr(`OFF_CTRL, USED | REM);
    period(32'd1000);
    $display("test periods done");
    conclude();
  end
endmodule
`default_nettype wire
